// ### design/ocb_pkg.sv
// Shared constants and types for the operator console boot control
package ocb_pkg;
   // Register offsets (byte addresses)
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   // Control field positions and reset value
   localparam int CTRL_DIAG_OFF_BIT = 0;
   localparam int CTRL_STAND_ALONE_BIT = 1;
   localparam int CTRL_DEV_LSB = 2;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // Status field positions
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_RUN_LAMP_BIT = 9;
   localparam int STAT_DC_LAMP_BIT = 10;
   localparam int STAT_BATTERY_LAMP_LAMP_BIT = 11;
   localparam int STAT_HALT_BIT = 12;
   localparam int STAT_ON_BATTERY_LAMP_BIT = 13;
   // Timing figures in their own units, and clock rate
   localparam int CLK_KHZ = 250000;
   localparam int SLOW_PERIOD_MS = 2000;
   localparam int FAST_PERIOD_MS = 100;
   localparam int DEBOUNCE_US = 5000;
   localparam int SLOW_HALF_CYC = SLOW_PERIOD_MS * (CLK_KHZ / 2);
   localparam int FAST_HALF_CYC = FAST_PERIOD_MS * (CLK_KHZ / 2);
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_KHZ / 1000;
   // Sequencer states
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_INIT = 9'h002,
      ST_HOLD = 9'h004,
      ST_CPUDIAG = 9'h008,
      ST_PRINT = 9'h010,
      ST_CONSOLE = 9'h020,
      ST_MEMDIAG = 9'h040,
      ST_BOOT = 9'h080,
      ST_RUN = 9'h100
   } ocb_state_e;
   // Module switch settings held in the control register
   typedef struct packed {
      logic [2:0] bootDev;
      logic standAlone;
      logic diagDisable;
   } ocb_ctrl_s;
   // Step requests to the processor core
   typedef struct packed {
      logic cpuDiag;
      logic memDiag;
      logic printRegs;
      logic boot;
   } ocb_step_s;
endpackage

// ### design/ocb_console.sv
// Operator console boot control: levers, key, lamps and start sequencer
//
// Operation
// - Restart lever acts on return to rest, per run/stop lever position.
// - Restart released at stop: processor-only init, no bus initialise.
// - After processor-only init, lever to run starts the boot routine.
// - Restart released at run: full initialise then boot routine.
// - Run/stop lever at run lets program continue; at stop halts it.
// - Console mode: processor diagnostics, print saved registers, prompt.
// - Device boot command: memory diagnostics, then secondary bootstrap.
// - Stand-alone: cpu diag, memory diag, then switch-selected bootstrap.
// - Diagnostics run on each start unless switch setting disables them.
// - Automatic boot device comes from the module switch setting.
// - Battery lamp dark when battery below minimum or absent.
// - Battery lamp slow flash, one per two seconds, while charging.
// - Battery lamp fast flash, ten per second, when on battery.
// - Battery lamp steady when battery present and fully charged.
// - DC lamp lit while DC power applied, dark otherwise.
// - Run lamp lit while program executes, dark when stopped.
// - Standby key removes logic DC, keeps memory supply and fans.
// - On main power loss, memory moves to battery with slow refresh.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns

// Two-flop synchroniser followed by a stability filter
module ocb_debounce #(
   parameter int CNT = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Raw and filtered level
   input wire logic rawIn,
   output logic cleanOut
);
   logic sync1_r;
   logic sync2_r;
   logic [23:0] cnt_r;

   // Synchroniser; first flop feeds only the second
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= rawIn;
         sync2_r <= sync1_r;
      end
   end

   // Accept a new level only after it held steady CNT cycles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 24'h000000;
         cleanOut <= 1'b0;
      end else if (sync2_r == cleanOut) begin
         cnt_r <= 24'h000000;
      end else if (cnt_r >= 24'(CNT - 1)) begin
         cnt_r <= 24'h000000;
         cleanOut <= sync2_r;
      end else begin
         cnt_r <= cnt_r + 24'h000001;
      end
   end
endmodule // ocb_debounce

module ocb_console #(
   parameter int DB_CYC = ocb_pkg::DEBOUNCE_CYC,
   parameter int SLOW_HALF = ocb_pkg::SLOW_HALF_CYC,
   parameter int FAST_HALF = ocb_pkg::FAST_HALF_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData,
   // Panel levers and key
   input wire logic run_stop_lever,
   input wire logic restartLever,
   input wire logic keyOn,
   input wire logic standby_position,
   // Power sensing
   input wire logic mainPowerOk,
   input wire logic battPresent,
   input wire logic battAboveMin,
   input wire logic battCharging,
   input wire logic battFull,
   // Processor core
   output logic cpuInitPulse,
   output logic bus_initialize_pulse,
   output logic cpuHalt,
   output ocb_pkg::ocb_step_s stepReq,
   output logic [2:0] bootDev,
   input wire logic stepDone,
   input wire logic bootCmd,
   input wire logic [2:0] bootCmdDev,
   // Power control
   output logic dcPowerEn,
   output logic memPowerEn,
   output logic fanEn,
   output logic memOnBattery,
   output logic refreshSlow,
   // Lamps
   output logic battery_lamp,
   output logic dc_power_lamp,
   output logic runLamp
);
   import ocb_pkg::*;

   logic runDb;
   logic restartDb;
   logic keyOnDb;
   logic stbyDb;
   logic restartPrev_r;
   logic keyPrev_r;
   logic restartRel;
   logic powerUp;
   ocb_ctrl_s ctrl_r;
   ocb_state_e state_r;
   ocb_state_e state_nxt;
   ocb_state_e seqStart;
   logic [31:0] flashCnt_r;
   logic flashPhase_r;
   logic [31:0] flashLim;

   // Clean every panel input
   ocb_debounce #(.CNT(DB_CYC)) uRun (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rawIn(run_stop_lever),
      .cleanOut(runDb)
   );
   ocb_debounce #(.CNT(DB_CYC)) uRestart (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rawIn(restartLever),
      .cleanOut(restartDb)
   );
   ocb_debounce #(.CNT(DB_CYC)) uKeyOn (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rawIn(keyOn),
      .cleanOut(keyOnDb)
   );
   ocb_debounce #(.CNT(DB_CYC)) uStby (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rawIn(standby_position),
      .cleanOut(stbyDb)
   );

   // Edge history of restart lever and power key
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         restartPrev_r <= 1'b0;
         keyPrev_r <= 1'b0;
      end else begin
         restartPrev_r <= restartDb;
         keyPrev_r <= keyOnDb;
      end
   end
   assign restartRel = restartPrev_r & ~restartDb;
   assign powerUp = keyOnDb & ~keyPrev_r;

   // Register writes: module switch settings
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
      end else if (regWrStb && regAddr == OFS_CTRL) begin
         ctrl_r <= regWrData[4:0];
      end
   end

   // Register reads, answered one cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 32'h00000000;
      end else if (regRdStb && regAddr == OFS_CTRL) begin
         regRdData <= {27'h0000000, ctrl_r};
      end else if (regRdStb && regAddr == OFS_STATUS) begin
         regRdData <= {18'h00000, memOnBattery, cpuHalt, battery_lamp,
                       dc_power_lamp, runLamp, state_r};
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   // First sequence step after an initialise
   always_comb begin
      if (!ctrl_r.diagDisable) begin
         seqStart = ST_CPUDIAG;
      end else if (ctrl_r.standAlone) begin
         seqStart = ST_BOOT;
      end else begin
         seqStart = ST_PRINT;
      end
   end

   // Start sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (powerUp) begin
               state_nxt = ST_INIT;
            end
         end
         ST_INIT: begin
            state_nxt = seqStart;
         end
         ST_HOLD: begin
            if (runDb) begin
               state_nxt = seqStart;
            end
         end
         ST_CPUDIAG: begin
            if (stepDone && ctrl_r.standAlone) begin
               state_nxt = ST_MEMDIAG;
            end else if (stepDone) begin
               state_nxt = ST_PRINT;
            end
         end
         ST_PRINT: begin
            if (stepDone) begin
               state_nxt = ST_CONSOLE;
            end
         end
         ST_CONSOLE: begin
            if (bootCmd && ctrl_r.diagDisable) begin
               state_nxt = ST_BOOT;
            end else if (bootCmd) begin
               state_nxt = ST_MEMDIAG;
            end
         end
         ST_MEMDIAG: begin
            if (stepDone) begin
               state_nxt = ST_BOOT;
            end
         end
         ST_BOOT: begin
            if (stepDone) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Restart release and power key off override any step
      if (!keyOnDb) begin
         state_nxt = ST_IDLE;
      end else if (restartRel && runDb) begin
         state_nxt = ST_INIT;
      end else if (restartRel) begin
         state_nxt = ST_HOLD;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Initialise pulses, one cycle on entry: processor on INIT or HOLD, bus on INIT only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpuInitPulse <= 1'b0;
         bus_initialize_pulse <= 1'b0;
      end else begin
         cpuInitPulse <= (state_nxt == ST_INIT || state_nxt == ST_HOLD)
                         && (state_nxt != state_r || restartRel);
         bus_initialize_pulse <= state_nxt == ST_INIT
                                 && (state_r != ST_INIT || restartRel);
      end
   end

   // Boot device: switches in stand-alone, command in console mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bootDev <= 3'h0;
      end else if (state_r == ST_CONSOLE && bootCmd) begin
         bootDev <= bootCmdDev;
      end else if (state_r == ST_INIT || state_r == ST_HOLD) begin
         bootDev <= ctrl_r.bootDev;
      end
   end

   // Step requests follow the state
   assign stepReq.cpuDiag = state_r == ST_CPUDIAG;
   assign stepReq.memDiag = state_r == ST_MEMDIAG;
   assign stepReq.printRegs = state_r == ST_PRINT;
   assign stepReq.boot = state_r == ST_BOOT;

   // Halt, power switching and plain lamps
   assign cpuHalt = ~runDb;
   assign dcPowerEn = keyOnDb & ~stbyDb;
   assign memPowerEn = keyOnDb | stbyDb;
   assign fanEn = keyOnDb | stbyDb;
   assign memOnBattery = ~mainPowerOk & battPresent & battAboveMin;
   assign refreshSlow = memOnBattery;
   assign dc_power_lamp = dcPowerEn & mainPowerOk;
   assign runLamp = runDb & dc_power_lamp & state_r != ST_IDLE
                    & state_r != ST_HOLD;

   // Flash timer, half period chosen by battery condition
   assign flashLim = memOnBattery ? 32'(FAST_HALF - 1)
                                  : 32'(SLOW_HALF - 1);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flashCnt_r <= 32'h00000000;
         flashPhase_r <= 1'b0;
      end else if (flashCnt_r >= flashLim) begin
         flashCnt_r <= 32'h00000000;
         flashPhase_r <= ~flashPhase_r;
      end else begin
         flashCnt_r <= flashCnt_r + 32'h00000001;
      end
   end

   // Battery lamp
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         battery_lamp <= 1'b0;
      end else if (!battPresent || !battAboveMin) begin
         battery_lamp <= 1'b0;
      end else if (!mainPowerOk) begin
         battery_lamp <= flashPhase_r;
      end else if (battFull) begin
         battery_lamp <= 1'b1;
      end else if (battCharging) begin
         battery_lamp <= flashPhase_r;
      end else begin
         battery_lamp <= 1'b1;
      end
   end

   // Checks
   AST_PROC_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(state_r == ST_HOLD) |-> cpuInitPulse && !bus_initialize_pulse)
      else $error("bus initialise on processor-only init");
   AST_HOLD_EXIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_HOLD && runDb && keyOnDb && !restartRel
      |=> state_r == $past(seqStart))
      else $error("run lever did not start routine");
   AST_FULL_INIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      bus_initialize_pulse |-> cpuInitPulse && state_r == ST_INIT)
      else $error("full init incomplete");
   AST_HALT: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(runDb) |-> cpuHalt && !runLamp)
      else $error("stop lever did not halt");
   AST_PROMPT: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_PRINT && stepDone && keyOnDb && !restartRel
      |=> stepReq == 4'h0 ##0 state_r == ST_CONSOLE)
      else $error("prompt did not follow print");
   AST_BOOTCMD: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_CONSOLE && bootCmd && !ctrl_r.diagDisable
      && keyOnDb && !restartRel
      |=> stepReq.memDiag && bootDev == $past(bootCmdDev))
      else $error("boot command skipped memory test");
   AST_STANDALONE: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_CPUDIAG && stepDone && ctrl_r.standAlone
      && keyOnDb && !restartRel |=> stepReq.memDiag)
      else $error("stand-alone order broken");
   AST_DIAG_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_INIT && ctrl_r.diagDisable && keyOnDb && !restartRel
      |=> !stepReq.cpuDiag && !stepReq.memDiag)
      else $error("diagnostics ran while disabled");
   AST_LAMP_DARK: assert property (@(posedge core_clk) disable iff (!rst_n)
      !battPresent || !battAboveMin |=> !battery_lamp)
      else $error("battery lamp lit without battery");
   AST_STANDBY: assert property (@(posedge core_clk) disable iff (!rst_n)
      stbyDb |-> !dcPowerEn && memPowerEn && fanEn && !dc_power_lamp)
      else $error("standby power wrong");
   COV_CONSOLE: cover property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_PRINT ##1 state_r == ST_CONSOLE);
   COV_BOOT: cover property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_MEMDIAG ##1 state_r == ST_BOOT);
   COV_HOLD: cover property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_HOLD ##1 state_r != ST_HOLD);
endmodule // ocb_console

// ### dv/ocb_core_model.sv
// Behavioural processor core that answers start sequencer step requests
`timescale 1ns/1ns

module ocb_core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Step handshake
   input wire ocb_pkg::ocb_step_s stepReq,
   input wire logic slow,
   output logic stepDone
);
   import ocb_pkg::*;

   logic [3:0] waitCnt_r;

   // Finish each requested step after a short or long stay, one pulse each
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stepDone <= 1'b0;
         waitCnt_r <= 4'h0;
      end else if (stepDone) begin
         stepDone <= 1'b0; // Pulse lasts one cycle only
         waitCnt_r <= 4'h0;
      end else if (stepReq != '0) begin
         if (waitCnt_r == (slow ? 4'h6 : 4'h1)) begin
            stepDone <= 1'b1;
         end else begin
            waitCnt_r <= waitCnt_r + 4'h1;
         end
      end else begin
         waitCnt_r <= 4'h0;
      end
   end
endmodule // ocb_core_model

// ### dv/tb_ocb_console.sv
// Self-checking bench for the operator console boot control
`timescale 1ns/1ns

module tb_ocb_console;
   import ocb_pkg::*;

   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic [31:0] regRdData;
   logic run_stop_lever = 1'b1;
   logic restartLever = 1'b0;
   logic keyOn = 1'b0;
   logic standby_position = 1'b0;
   logic mainPowerOk = 1'b1;
   logic battPresent = 1'b1;
   logic battAboveMin = 1'b1;
   logic battCharging = 1'b0;
   logic battFull = 1'b1;
   logic cpuInitPulse, bus_initialize_pulse, cpuHalt, stepDone;
   ocb_step_s stepReq;
   logic [2:0] bootDev;
   logic bootCmd = 1'b0;
   logic [2:0] bootCmdDev = 3'h0;
   logic dcPowerEn, memPowerEn, fanEn, memOnBattery, refreshSlow;
   logic battery_lamp, dc_power_lamp, runLamp;
   logic slow = 1'b0;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int cntCpu = 0;
   int cntBus = 0;
   int nLog = 0;
   logic [15:0] stepLog = 16'h0;
   logic [31:0] rdVal;

   always #2 core_clk = ~core_clk;

   ocb_console #(.DB_CYC(4), .SLOW_HALF(40), .FAST_HALF(8)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .run_stop_lever(run_stop_lever),
      .restartLever(restartLever), .keyOn(keyOn),
      .standby_position(standby_position), .mainPowerOk(mainPowerOk),
      .battPresent(battPresent), .battAboveMin(battAboveMin),
      .battCharging(battCharging), .battFull(battFull),
      .cpuInitPulse(cpuInitPulse),
      .bus_initialize_pulse(bus_initialize_pulse), .cpuHalt(cpuHalt),
      .stepReq(stepReq), .bootDev(bootDev), .stepDone(stepDone),
      .bootCmd(bootCmd), .bootCmdDev(bootCmdDev), .dcPowerEn(dcPowerEn),
      .memPowerEn(memPowerEn), .fanEn(fanEn), .memOnBattery(memOnBattery),
      .refreshSlow(refreshSlow), .battery_lamp(battery_lamp),
      .dc_power_lamp(dc_power_lamp), .runLamp(runLamp));

   ocb_core_model i_core (
      .core_clk(core_clk), .rst_n(rst_n), .stepReq(stepReq), .slow(slow),
      .stepDone(stepDone));

   // Count initialise pulses and log finished steps in order
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cpuInitPulse === 1'b1) cntCpu <= cntCpu + 1;
      if (bus_initialize_pulse === 1'b1) cntBus <= cntBus + 1;
      if (stepDone === 1'b1 && stepReq != '0) begin
         stepLog <= {stepLog[11:0], stepReq};
         nLog <= nLog + 1;
      end
      if (cyc == 30000) begin
         num_errors = num_errors + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWrStb <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrStb <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regRdStb <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      @(posedge core_clk);
      d = regRdData; // Data stand only in the cycle after the strobe
   endtask

   // Poll the status word until the sequencer reaches a state
   task automatic waitState(input ocb_state_e st);
      int i;
      for (i = 0; i < 100; i++) begin
         rd(OFS_STATUS, rdVal);
         if (rdVal[8:0] === st) break;
      end
      chk(32'(rdVal[8:0]), 32'(st));
   endtask

   task automatic waitLog(input int n);
      int i;
      for (i = 0; i < 200 && nLog < n; i++) settle(1);
   endtask

   // Clear counters and step log between scenarios
   task automatic clearLog();
      @(posedge core_clk);
      stepLog <= 16'h0;
      nLog <= 0;
      cntCpu <= 0;
      cntBus <= 0;
   endtask

   // Press and let go of the restart lever, each level held past debounce
   task automatic restart();
      clearLog();
      restartLever <= 1'b1;
      settle(12);
      restartLever <= 1'b0;
      settle(12);
   endtask

   task automatic toggles(input int exp);
      int n;
      logic last;
      n = 0;
      @(posedge core_clk);
      last = battery_lamp;
      repeat (160) begin
         @(posedge core_clk);
         if (battery_lamp !== last) n++;
         last = battery_lamp;
      end
      chk(32'(n), 32'(exp));
   endtask

   initial begin
      settle(10);
      rst_n <= 1'b1;
      settle(12);
      // Reset values and an unmapped address
      rd(OFS_CTRL, rdVal); chk(rdVal, 32'(CTRL_RST));
      rd(4'h8, rdVal); chk(rdVal, 32'h0);
      waitState(ST_IDLE);
      chk(32'(dc_power_lamp), 32'h0);
      // Power up in console mode
      wr(OFS_CTRL, 32'h0);
      clearLog();
      keyOn <= 1'b1;
      waitLog(2);
      waitState(ST_CONSOLE);
      chk(32'(stepLog), 32'h0082);
      chk(32'(dc_power_lamp), 32'h1);
      chk(32'(dcPowerEn), 32'h1);
      wr(OFS_STATUS, 32'hffffffff);
      waitState(ST_CONSOLE);
      // Device boot command from the console
      clearLog();
      bootCmd <= 1'b1;
      bootCmdDev <= 3'h5;
      @(posedge core_clk);
      bootCmd <= 1'b0;
      waitLog(2);
      waitState(ST_RUN);
      chk(32'(stepLog), 32'h0041);
      chk(32'(bootDev), 32'h5);
      chk(32'(runLamp), 32'h1);
      chk(32'(cpuHalt), 32'h0);
      // Restart at stop: processor only, then run starts the routine
      run_stop_lever <= 1'b0;
      settle(12);
      chk(32'(cpuHalt), 32'h1);
      chk(32'(runLamp), 32'h0);
      restart();
      waitState(ST_HOLD);
      chk(32'(cntCpu), 32'h1);
      chk(32'(cntBus), 32'h0);
      run_stop_lever <= 1'b1;
      waitLog(2);
      waitState(ST_CONSOLE);
      chk(32'(stepLog), 32'h0082);
      // Restart at run: full initialise, one pulse of each kind
      restart();
      waitLog(2);
      waitState(ST_CONSOLE);
      chk(32'(cntCpu), 32'h1);
      chk(32'(cntBus), 32'h1);
      // Stand-alone boot from switch-selected device, slow core
      wr(OFS_CTRL, 32'h0e);
      slow <= 1'b1;
      restart();
      waitLog(3);
      chk(32'(stepLog), 32'h0841);
      chk(32'(bootDev), 32'h3);
      // Stand-alone with diagnostics switched off
      wr(OFS_CTRL, 32'h1b);
      slow <= 1'b0;
      restart();
      waitLog(1);
      settle(30);
      chk(32'(nLog), 32'h1);
      chk(32'(stepLog), 32'h0001);
      chk(32'(bootDev), 32'h6);
      // Boot command outside the console is ignored
      bootCmd <= 1'b1;
      bootCmdDev <= 3'h1;
      @(posedge core_clk);
      bootCmd <= 1'b0;
      settle(4);
      chk(32'(bootDev), 32'h6);
      // Console mode with diagnostics off: print, then boot at once
      wr(OFS_CTRL, 32'h01);
      restart();
      waitLog(1);
      waitState(ST_CONSOLE);
      chk(32'(stepLog), 32'h0002);
      clearLog();
      bootCmd <= 1'b1;
      bootCmdDev <= 3'h2;
      @(posedge core_clk);
      bootCmd <= 1'b0;
      waitLog(1);
      waitState(ST_RUN);
      chk(32'(stepLog), 32'h0001);
      chk(32'(bootDev), 32'h2);
      // Battery lamp modes
      chk(32'(battery_lamp), 32'h1);
      battFull <= 1'b0;
      battCharging <= 1'b1;
      settle(4);
      toggles(4);
      mainPowerOk <= 1'b0;
      settle(4);
      toggles(20);
      chk(32'(memOnBattery), 32'h1);
      chk(32'(refreshSlow), 32'h1);
      battAboveMin <= 1'b0;
      settle(4);
      toggles(0);
      chk(32'(battery_lamp), 32'h0);
      battAboveMin <= 1'b1;
      battPresent <= 1'b0;
      mainPowerOk <= 1'b1;
      settle(4);
      chk(32'(battery_lamp), 32'h0);
      chk(32'(memOnBattery), 32'h0);
      // Standby key keeps memory and fans, drops logic power
      standby_position <= 1'b1;
      settle(12);
      chk(32'(dcPowerEn), 32'h0);
      chk(32'(memPowerEn), 32'h1);
      chk(32'(fanEn), 32'h1);
      chk(32'(dc_power_lamp), 32'h0);
      report_and_stop();
   end
endmodule // tb_ocb_console
